// [ioc_regs.v]
// Purpose: Output clock select, in-band engine control and drive strength registers
// Assumes: All inputs synchronous to clk_sys, clock sources sampled as levels
// Notes: Byte-wide register port, read data one cycle after the read strobe
//
// Function
// - Bit 7 of output clock register reads whether selected recovered clock is ready.
// - Bits 4:2 pick crystal or port 1..5 recovered clock; 6,7 reserved; reset 0.
// - Bit 1 enables sync output (reset 1); bit 0 picks 25/125 MHz (reset 0).
// - In-band enable bit 31 loads strap pin level after reset.
// - Bit 30 set drops management frames whose destination differs from switch address.
// - Writing one to bit 29 restarts the in-band engine; bit self-clears.
// - Bits 23:22 pick response transmit queue, reset 01.
// - Bits 18:16 pick management port 1..7, 111 reserved, reset 110.
// - Bits 15:0 hold writable frame type value, reset 0x40FE.
// - Drive bits 6:4 store high-speed setting, reset 110.
// - Drive bits 2:0 store low-speed setting, reset 010.
`timescale 1ns/1ps
`include "ioc_defines.vh"

module ioc_regs (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Clock sources and readiness
  input wire crystal_input_pin,
  input wire [4:0] recovered_clk,
  input wire [4:0] recovered_clk_ready,
  // Strap
  input wire port7_rx_valid_strap_pin,
  // Sync clock output
  output reg sync_clock_out,
  output reg sync_clock_out_enable,
  output reg sync_clock_fast_sel,
  // In-band engine configuration
  output reg in_band_access_enable,
  output reg in_band_access_reset,
  output reg [1:0] iba_resp_queue,
  output reg [2:0] iba_mgmt_port,
  output reg [15:0] iba_frame_type,
  // Received management frame check
  input wire frame_valid,
  input wire [47:0] frame_dest_addr,
  input wire [47:0] switch_addr,
  output reg frame_accept,
  output reg frame_drop,
  // Drive strength
  output reg [2:0] drive_high_speed,
  output reg [2:0] drive_low_speed
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [2:0] clk_src_reg;
  reg clk_en_reg;
  reg clk_freq_reg;
  reg clk_rdy_reg;
  reg iba_en_reg;
  reg iba_match_reg;
  reg iba_rst_reg;
  reg [1:0] iba_queue_reg;
  reg [2:0] iba_port_reg;
  reg [15:0] iba_tpid_reg;
  reg [2:0] drv_hi_reg;
  reg [2:0] drv_lo_reg;
  reg drv_rsv7_reg;
  reg drv_rsv3_reg;
  reg strap_done_reg;
  reg [7:0] rdata_next;
  reg sel_level_next;
  reg sel_ready_next;

  wire wr_ock = reg_wr && (reg_addr == `IOC_ADDR_OUT_CLK);
  wire wr_b3 = reg_wr && (reg_addr == `IOC_ADDR_IBA_B3);
  wire wr_b2 = reg_wr && (reg_addr == `IOC_ADDR_IBA_B2);
  wire wr_b1 = reg_wr && (reg_addr == `IOC_ADDR_IBA_B1);
  wire wr_b0 = reg_wr && (reg_addr == `IOC_ADDR_IBA_B0);
  wire wr_drv = reg_wr && (reg_addr == `IOC_ADDR_DRIVE);

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // Reserved codes give a quiet output and not-ready, never a stale source
  always @* begin
    sel_level_next = 1'b0;
    sel_ready_next = 1'b0;
    case (clk_src_reg)
      3'h0: begin
        sel_level_next = crystal_input_pin;
      end
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
        sel_level_next = recovered_clk[clk_src_reg - 3'h1];
        sel_ready_next = recovered_clk_ready[clk_src_reg - 3'h1];
      end
      default: begin
        sel_level_next = 1'b0;
        sel_ready_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_src_reg <= `IOC_OCK_SRC_RST;
      clk_en_reg <= `IOC_OCK_EN_RST;
      clk_freq_reg <= `IOC_OCK_FREQ_RST;
      clk_rdy_reg <= 1'b0;
      iba_en_reg <= 1'b0;
      iba_match_reg <= `IOC_IBA_MATCH_RST;
      iba_rst_reg <= 1'b0;
      iba_queue_reg <= `IOC_IBA_QUEUE_RST;
      iba_port_reg <= `IOC_IBA_PORT_RST;
      iba_tpid_reg <= `IOC_IBA_TPID_RST;
      drv_hi_reg <= `IOC_DRV_HI_RST;
      drv_lo_reg <= `IOC_DRV_LO_RST;
      drv_rsv7_reg <= `IOC_DRV_RSV_RST;
      drv_rsv3_reg <= `IOC_DRV_RSV_RST;
      strap_done_reg <= 1'b0;
    end else begin
      clk_rdy_reg <= sel_ready_next;
      if (wr_ock) begin
        // Bit 7 and bits 6:5 are not stored
        clk_src_reg <= reg_wdata[`IOC_OCK_SRC_MSB:`IOC_OCK_SRC_LSB];
        clk_en_reg <= reg_wdata[`IOC_OCK_EN_BIT];
        clk_freq_reg <= reg_wdata[`IOC_OCK_FREQ_BIT];
      end
      // Strap is caught on the first edge after release; it beats a write there
      strap_done_reg <= 1'b1;
      if (!strap_done_reg) begin
        iba_en_reg <= port7_rx_valid_strap_pin;
      end else if (wr_b3) begin
        iba_en_reg <= reg_wdata[`IOC_IBA_EN_BIT - 24];
      end
      if (wr_b3) begin
        iba_match_reg <= reg_wdata[`IOC_IBA_MATCH_BIT - 24];
      end
      // One-cycle pulse, bit drops back on its own
      iba_rst_reg <= wr_b3 && reg_wdata[`IOC_IBA_RST_BIT - 24];
      if (wr_b2) begin
        iba_queue_reg <= reg_wdata[`IOC_IBA_QUEUE_MSB-16:`IOC_IBA_QUEUE_LSB-16];
        iba_port_reg <= reg_wdata[`IOC_IBA_PORT_MSB-16:`IOC_IBA_PORT_LSB-16];
      end
      if (wr_b1) begin
        iba_tpid_reg[15:8] <= reg_wdata;
      end
      if (wr_b0) begin
        iba_tpid_reg[7:0] <= reg_wdata;
      end
      if (wr_drv) begin
        drv_hi_reg <= reg_wdata[`IOC_DRV_HI_MSB:`IOC_DRV_HI_LSB];
        drv_lo_reg <= reg_wdata[`IOC_DRV_LO_MSB:`IOC_DRV_LO_LSB];
        drv_rsv7_reg <= reg_wdata[`IOC_DRV_RSV7_BIT];
        drv_rsv3_reg <= reg_wdata[`IOC_DRV_RSV3_BIT];
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `IOC_ADDR_OUT_CLK: begin
        rdata_next = {clk_rdy_reg, 2'b00, clk_src_reg, clk_en_reg, clk_freq_reg};
      end
      `IOC_ADDR_IBA_B3: begin
        rdata_next = {iba_en_reg, iba_match_reg, iba_rst_reg, 5'h00};
      end
      `IOC_ADDR_IBA_B2: begin
        rdata_next = {iba_queue_reg, 3'b000, iba_port_reg};
      end
      `IOC_ADDR_IBA_B1: begin
        rdata_next = iba_tpid_reg[15:8];
      end
      `IOC_ADDR_IBA_B0: begin
        rdata_next = iba_tpid_reg[7:0];
      end
      `IOC_ADDR_DRIVE: begin
        rdata_next = {drv_rsv7_reg, drv_hi_reg, drv_rsv3_reg, drv_lo_reg};
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      sync_clock_out <= 1'b0;
      sync_clock_out_enable <= 1'b0;
      sync_clock_fast_sel <= 1'b0;
      in_band_access_enable <= 1'b0;
      in_band_access_reset <= 1'b0;
      iba_resp_queue <= `IOC_IBA_QUEUE_RST;
      iba_mgmt_port <= `IOC_IBA_PORT_RST;
      iba_frame_type <= `IOC_IBA_TPID_RST;
      frame_accept <= 1'b0;
      frame_drop <= 1'b0;
      drive_high_speed <= `IOC_DRV_HI_RST;
      drive_low_speed <= `IOC_DRV_LO_RST;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
      // Level sampling adds one cycle of delay; fine for a sync reference
      sync_clock_out <= clk_en_reg & sel_level_next;
      sync_clock_out_enable <= clk_en_reg;
      sync_clock_fast_sel <= clk_freq_reg;
      in_band_access_enable <= iba_en_reg;
      in_band_access_reset <= iba_rst_reg;
      iba_resp_queue <= iba_queue_reg;
      iba_mgmt_port <= iba_port_reg;
      iba_frame_type <= iba_tpid_reg;
      drive_high_speed <= drv_hi_reg;
      drive_low_speed <= drv_lo_reg;
      // Frames are only judged while the engine is enabled
      frame_accept <= frame_valid && iba_en_reg &&
                      (!iba_match_reg || (frame_dest_addr == switch_addr));
      frame_drop <= frame_valid && iba_en_reg && iba_match_reg &&
                    (frame_dest_addr != switch_addr);
    end
  end

endmodule // ioc_regs

// [ioc_defines.vh]
// Purpose: Constants for the global I/O, output clock and in-band control registers
// Assumes: Byte-wide register port, byte addresses as printed
// Notes: Multi-byte register is big-endian, lowest address holds bits 31:24
`ifndef IOC_DEFINES_VH
`define IOC_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define IOC_ADDR_OUT_CLK 16'h0103
`define IOC_ADDR_IBA_B3 16'h0104
`define IOC_ADDR_IBA_B2 16'h0105
`define IOC_ADDR_IBA_B1 16'h0106
`define IOC_ADDR_IBA_B0 16'h0107
`define IOC_ADDR_DRIVE 16'h010D

// ----------------------------------------
// Output clock control fields
// ----------------------------------------
`define IOC_OCK_RDY_BIT 7
`define IOC_OCK_SRC_MSB 4
`define IOC_OCK_SRC_LSB 2
`define IOC_OCK_EN_BIT 1
`define IOC_OCK_FREQ_BIT 0
`define IOC_OCK_SRC_RST 3'h0
`define IOC_OCK_EN_RST 1'h1
`define IOC_OCK_FREQ_RST 1'h0
`define IOC_SRC_CRYSTAL 3'h0
`define IOC_SRC_LAST_PORT 3'h5

// ----------------------------------------
// In-band control fields (bit positions within 32-bit word)
// ----------------------------------------
`define IOC_IBA_EN_BIT 31
`define IOC_IBA_MATCH_BIT 30
`define IOC_IBA_RST_BIT 29
`define IOC_IBA_QUEUE_MSB 23
`define IOC_IBA_QUEUE_LSB 22
`define IOC_IBA_PORT_MSB 18
`define IOC_IBA_PORT_LSB 16
`define IOC_IBA_TPID_MSB 15
`define IOC_IBA_TPID_LSB 0
`define IOC_IBA_MATCH_RST 1'h0
`define IOC_IBA_QUEUE_RST 2'h1
`define IOC_IBA_PORT_RST 3'h6
`define IOC_IBA_TPID_RST 16'h40FE

// ----------------------------------------
// Drive strength fields
// ----------------------------------------
`define IOC_DRV_RSV7_BIT 7
`define IOC_DRV_HI_MSB 6
`define IOC_DRV_HI_LSB 4
`define IOC_DRV_RSV3_BIT 3
`define IOC_DRV_LO_MSB 2
`define IOC_DRV_LO_LSB 0
`define IOC_DRV_HI_RST 3'h6
`define IOC_DRV_LO_RST 3'h2
`define IOC_DRV_RSV_RST 1'h0

`endif

// [ioc_regs_assertions.sv]
// Purpose: Port-level timing checks for ioc_regs
// Assumes: One clock domain, bound to every ioc_regs instance
// Notes: Field checks assume no rewrite of the same byte within two cycles
`timescale 1ns/1ps
module ioc_regs_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  // Outputs and frame check
  input wire sync_clock_out,
  input wire sync_clock_out_enable,
  input wire in_band_access_reset,
  input wire [1:0] iba_resp_queue,
  input wire [2:0] iba_mgmt_port,
  input wire [15:0] iba_frame_type,
  input wire frame_valid,
  input wire [47:0] frame_dest_addr,
  input wire [47:0] switch_addr,
  input wire frame_accept,
  input wire frame_drop,
  input wire [2:0] drive_high_speed,
  input wire [2:0] drive_low_speed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_read_answered: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 16'h0200 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_drop_needs_mismatch: assert property (
    frame_drop |-> !frame_accept && $past(frame_valid) &&
    $past(frame_dest_addr) != $past(switch_addr))
    else $error("drop without an address mismatch");
  a_reset_pulse_single: assert property (
    $rose(in_band_access_reset) |=> !in_band_access_reset)
    else $error("engine reset pulse longer than one cycle");
  a_reset_pulse_cause: assert property (
    $rose(in_band_access_reset) |-> $past(reg_wr, 2) &&
    $past(reg_addr, 2) == 16'h0104 && ($past(reg_wdata, 2) & 8'h20) != 8'h00)
    else $error("engine reset pulse without a write of one");
  a_sync_gated_off: assert property (!sync_clock_out_enable |-> !sync_clock_out)
    else $error("sync clock toggles while disabled");
  a_frame_type_low: assert property (
    reg_wr && reg_addr == 16'h0107 |-> ##2 iba_frame_type[7:0] == $past(reg_wdata, 2))
    else $error("frame type low byte not updated");
  a_port_queue_write: assert property (
    reg_wr && reg_addr == 16'h0105 |->
    ##2 {iba_resp_queue, 3'h0, iba_mgmt_port} == ($past(reg_wdata, 2) & 8'hC7))
    else $error("queue or port field not updated");
  a_drive_write: assert property (
    reg_wr && reg_addr == 16'h010D |->
    ##2 {1'b0, drive_high_speed, 1'b0, drive_low_speed} == ($past(reg_wdata, 2) & 8'h77))
    else $error("drive strength fields not updated");
  c_drop: cover property (frame_drop);
  c_accept: cover property (frame_accept);
  c_engine_reset: cover property (in_band_access_reset);
endmodule // ioc_regs_chk

bind ioc_regs ioc_regs_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sync_clock_out(sync_clock_out), .sync_clock_out_enable(sync_clock_out_enable),
  .in_band_access_reset(in_band_access_reset),
  .iba_resp_queue(iba_resp_queue), .iba_mgmt_port(iba_mgmt_port),
  .iba_frame_type(iba_frame_type),
  .frame_valid(frame_valid), .frame_dest_addr(frame_dest_addr),
  .switch_addr(switch_addr), .frame_accept(frame_accept), .frame_drop(frame_drop),
  .drive_high_speed(drive_high_speed), .drive_low_speed(drive_low_speed)
);

// [ioc_regs_test.sv]
// Purpose: Directed register, clock select and frame check tests for ioc_regs
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Each strobe task (wr, rd, frame) waits one edge first so strobes never toggle twice at once
`timescale 1ns/1ps
module ioc_regs_test;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_rd = 1'b0;
  reg crystal_input_pin = 1'b0;
  reg [4:0] recovered_clk = 5'h00;
  reg [4:0] recovered_clk_ready = 5'h00;
  reg [4:0] sel = 5'h00;
  reg port7_rx_valid_strap_pin = 1'b1;
  reg frame_valid = 1'b0;
  reg [47:0] frame_dest_addr = 48'h000000000000;
  wire [47:0] switch_addr = 48'h0A0B0C0D0E0F;
  wire [7:0] reg_rdata;
  wire [15:0] iba_frame_type;
  wire [2:0] iba_mgmt_port, drive_high_speed, drive_low_speed;
  wire [1:0] iba_resp_queue;
  wire reg_rvalid, sync_clock_out, sync_clock_out_enable, sync_clock_fast_sel;
  wire in_band_access_enable, in_band_access_reset, frame_accept, frame_drop;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer i;

  ioc_regs u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .crystal_input_pin(crystal_input_pin), .recovered_clk(recovered_clk),
    .recovered_clk_ready(recovered_clk_ready),
    .port7_rx_valid_strap_pin(port7_rx_valid_strap_pin),
    .sync_clock_out(sync_clock_out), .sync_clock_out_enable(sync_clock_out_enable),
    .sync_clock_fast_sel(sync_clock_fast_sel),
    .in_band_access_enable(in_band_access_enable),
    .in_band_access_reset(in_band_access_reset),
    .iba_resp_queue(iba_resp_queue), .iba_mgmt_port(iba_mgmt_port),
    .iba_frame_type(iba_frame_type),
    .frame_valid(frame_valid), .frame_dest_addr(frame_dest_addr),
    .switch_addr(switch_addr), .frame_accept(frame_accept), .frame_drop(frame_drop),
    .drive_high_speed(drive_high_speed), .drive_low_speed(drive_low_speed)
  );

  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task step();
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    step();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    step();
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    chk({7'h00, reg_rvalid, reg_rdata}, {8'h01, e});
  endtask
  task frame(input logic [47:0] d, input logic acc, input logic drp);
    step();
    frame_dest_addr = d;
    frame_valid = 1'b1;
    step();
    frame_valid = 1'b0;
    chk({frame_accept, frame_drop}, {acc, drp});
  endtask
  task do_reset(input logic s);
    port7_rx_valid_strap_pin = s;
    rst_b = 1'b0;
    repeat (4) step();
    rst_b = 1'b1;
    repeat (2) step();
  endtask
  task report_and_stop();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    do_reset(1'b1);
    rd(16'h0103, 8'h02);
    rd(16'h0104, 8'h80);
    rd(16'h0105, 8'h46);
    rd(16'h0106, 8'h40);
    rd(16'h0107, 8'hFE);
    rd(16'h010D, 8'h62);
    rd(16'h0200, 8'h00);
    chk({sync_clock_out_enable, sync_clock_fast_sel, in_band_access_enable}, 3'h5);
    chk({iba_resp_queue, iba_mgmt_port}, 5'h0E);
    chk(iba_frame_type, 16'h40FE);
    chk({drive_high_speed, drive_low_speed}, 6'h32);
    for (i = 0; i <= 5; i++) begin
      sel = (i == 0) ? 5'h00 : 5'h01 << (i - 1);
      recovered_clk_ready = sel;
      wr(16'h0103, {3'h0, i[2:0], 2'h2});
      rd(16'h0103, {i != 0, 2'h0, i[2:0], 2'h2});
      crystal_input_pin = (i == 0);
      recovered_clk = sel;
      repeat (2) step();
      chk(sync_clock_out, 1'b1);
      crystal_input_pin = 1'b0;
      recovered_clk = ~sel;
      repeat (2) step();
      chk(sync_clock_out, 1'b0);
      // Only the selected port's readiness may show
      recovered_clk_ready = ~sel;
      rd(16'h0103, {3'h0, i[2:0], 2'h2});
    end
    crystal_input_pin = 1'b1;
    recovered_clk = 5'h1F;
    recovered_clk_ready = 5'h1F;
    wr(16'h0103, 8'h1B);
    rd(16'h0103, 8'h1B);
    chk(sync_clock_out, 1'b0);
    wr(16'h0103, 8'hFF);
    rd(16'h0103, 8'h1F);
    chk({sync_clock_out, sync_clock_fast_sel}, 2'h1);
    wr(16'h0103, 8'hE1);
    rd(16'h0103, 8'h01);
    chk({sync_clock_out_enable, sync_clock_out}, 2'h0);
    wr(16'h0104, 8'hFF);
    step();
    chk(in_band_access_reset, 1'b1);
    rd(16'h0104, 8'hC0);
    frame(48'h0A0B0C0D0E0E, 1'b0, 1'b1);
    frame(48'h0A0B0C0D0E0F, 1'b1, 1'b0);
    wr(16'h0104, 8'h80);
    frame(48'h0A0B0C0D0E0E, 1'b1, 1'b0);
    wr(16'h0104, 8'h00);
    frame(48'h0A0B0C0D0E0E, 1'b0, 1'b0);
    wr(16'h0105, 8'hFF);
    rd(16'h0105, 8'hC7);
    chk({iba_resp_queue, iba_mgmt_port}, 5'h1F);
    wr(16'h0106, 8'h12);
    wr(16'h0107, 8'h34);
    rd(16'h0106, 8'h12);
    chk(iba_frame_type, 16'h1234);
    wr(16'h010D, 8'hFF);
    rd(16'h010D, 8'hFF);
    chk({drive_high_speed, drive_low_speed}, 6'h3F);
    wr(16'h0200, 8'hFF);
    rd(16'h0200, 8'h00);
    do_reset(1'b0);
    rd(16'h0104, 8'h00);
    chk(in_band_access_enable, 1'b0);
    rd(16'h010D, 8'h62);
    report_and_stop();
  end

  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule // ioc_regs_test
